// *** design/spsd_pkg.sv ***
// Constants, register map and carrier types for the serial port setup decoder.
// Assumes a single 125 MHz clock and a plain strobe-based register port.
// Overview of operation
// - Port code 00 standard, 01 uses rate word.
// - Unsupported codes raise configuration error flag.
// - Mode field: 0 host command, 1 raw.
// - Rate codes 00..04 give 1.2K to 19.2K.
// - Format codes set data, stop, parity bits.
// - Reply delay is BCD steps of 10 ms.
// - Node number BCD 00 through 31.
// - Raw mode start code enable 0/1.
// - Raw end: count, end code, or CRLF.
// - Start code byte in low delimiter bits.
// - Byte count 00 means 256 bytes.
// - End code byte in high delimiter bits.
// - Out of range falls back to safe default.
// - Settings apply only after transfer strobe.
// - Log style 0 shifts, 1 keeps first seven.
// - Other log style disables error recording.
// - Cycle monitor enable 0 detects, 1 suppresses.
package spsd_pkg;

  localparam logic [15:0] ADDR_MODE = 16'h19fa;
  localparam logic [15:0] ADDR_RATE = 16'h19fb;
  localparam logic [15:0] ADDR_DELAY = 16'h19fc;
  localparam logic [15:0] ADDR_STATION = 16'h19fd;
  localparam logic [15:0] ADDR_DELIM = 16'h19fe;
  localparam logic [15:0] ADDR_LOG = 16'h19ff;
  localparam logic [15:0] ADDR_APPLY = 16'h1a00;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h1a01;
  localparam logic [15:0] ADDR_IRQ_CLR = 16'h1a02;
  localparam logic [15:0] ADDR_IRQ_EN = 16'h1a03;
  localparam logic [15:0] ADDR_STATUS = 16'h1a04;

  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [2:0] RATE_STD = 3'h3;
  localparam logic [3:0] FMT_STD = 4'h3;
  localparam logic [3:0] FMT_MAX = 4'hb;
  localparam logic [3:0] RATE_MAX = 4'h4;
  localparam logic [7:0] NODE_MAX = 8'h31;
  localparam logic [3:0] LOG_KEEP = 4'h7;

  // Reply delay unit is 10 ms; DELAY_STEP_CYC clock cycles per step.
  localparam int CLK_HZ = 125000000;
  localparam int DELAY_STEP_MS = 10;
  localparam int DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;

  localparam int IRQ_CFG_ERR = 0;
  localparam int IRQ_LONG_CYC = 1;
  localparam int IRQ_LOG_FULL = 2;

  typedef enum logic [1:0] {
    SPSD_PAR_EVEN = 2'h0,
    SPSD_PAR_ODD = 2'h1,
    SPSD_PAR_NONE = 2'h2
  } spsd_parity_t;

  typedef enum logic [1:0] {
    SPSD_END_COUNT = 2'h0,
    SPSD_END_CODE = 2'h1,
    SPSD_END_CRLF = 2'h2
  } spsd_end_t;

  typedef enum logic [2:0] {
    SPSD_ST_IDLE = 3'b001,
    SPSD_ST_WAIT = 3'b010,
    SPSD_ST_GO = 3'b100
  } spsd_state_t;

  // Decoded port setup as seen by the frame engine.
  typedef struct packed {
    logic raw_mode;
    logic [2:0] rate_sel;
    logic data8;
    logic stop2;
    spsd_parity_t parity;
    logic [13:0] delay_steps;
    logic [4:0] node;
    logic start_en;
    logic [7:0] start_code;
    spsd_end_t end_mode;
    logic [7:0] end_code;
    logic [8:0] rx_count;
  } spsd_cfg_t;

  // Decoded error log policy.
  typedef struct packed {
    logic log_on;
    logic keep_first;
    logic cyc_mon_on;
  } spsd_log_t;

endpackage

// *** design/spsd_top.sv ***
// Serial port setup decoder: staged setup words, apply, decode, reply timer.
// Assumes software writes words over a strobe port and pulses apply.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module spsd_top
  import spsd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic reply_req_i,
  input wire logic long_cycle_i,
  input wire logic error_event_i,
  output spsd_cfg_t cfg_o,
  output spsd_log_t log_o,
  output logic config_error_flag_o,
  output logic reply_go_o,
  output logic log_write_o,
  output logic [2:0] log_slot_o,
  output logic log_shift_o,
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Two BCD digits are valid when each digit is at most nine.
  function automatic logic bcd_ok(input logic [7:0] v);
    bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction

  // Four BCD digits to a binary count of steps.
  function automatic logic [13:0] bcd4(input logic [15:0] v);
    bcd4 = 14'(v[15:12]) * 14'h3e8 + 14'(v[11:8]) * 14'h064
         + 14'(v[7:4]) * 14'h00a + 14'(v[3:0]);
  endfunction

  typedef struct packed {
    logic [15:0] mode_w;
    logic [15:0] rate_w;
    logic [15:0] delay_w;
    logic [15:0] station_w;
    logic [15:0] delim_w;
    logic [15:0] log_w;
    spsd_cfg_t cfg;
    spsd_log_t logp;
    logic cfg_err;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic irq;
    logic [15:0] rdata;
    spsd_state_t st;
    logic [23:0] tick;
    logic [13:0] steps;
    logic go;
    logic [2:0] log_cnt;
    logic log_wr;
    logic log_sh;
    logic [2:0] slot;
  } spsd_regs_t;

  spsd_regs_t r;
  spsd_regs_t next_r;
  spsd_cfg_t dec;
  spsd_log_t dlog;
  logic derr;

  //////////////////////////////////////////////////////////////////////////
  // Decode the staged words; used only when apply is written.
  always_comb begin
    logic [3:0] pcode;
    logic [3:0] mcode;
    logic [7:0] rcode;
    logic [7:0] fcode;
    logic [3:0] fidx;
    logic [3:0] scode;
    logic [3:0] ecode;
    logic bad;
    pcode = r.mode_w[3:0];
    mcode = r.mode_w[15:12];
    rcode = r.rate_w[7:0];
    fcode = r.rate_w[15:8];
    fidx = fcode[3:0];
    scode = r.station_w[11:8];
    ecode = r.station_w[15:12];
    bad = 1'b0;
    // unused bits ignored: mode word bits 4..11 never read.
    if (pcode > 4'h1) bad = 1'b1;
    if (mcode > 4'h1) bad = 1'b1;
    if (pcode == 4'h1 && (fcode > 8'(FMT_MAX) || rcode > 8'(RATE_MAX))) begin
      bad = 1'b1;
    end
    if (mcode == 4'h0 && !bcd_ok(r.delay_w[15:8])) bad = 1'b1;
    if (mcode == 4'h0 && !bcd_ok(r.delay_w[7:0])) bad = 1'b1;
    if (mcode == 4'h0 && (!bcd_ok(r.station_w[7:0])
        || r.station_w[7:0] > NODE_MAX)) begin
      bad = 1'b1;
    end
    if (mcode == 4'h1 && (scode > 4'h1 || ecode > 4'h2)) bad = 1'b1;
    derr = bad;
    dec = '0;
    dec.raw_mode = (mcode == 4'h1);
    if (pcode == 4'h1) begin
      dec.rate_sel = rcode[2:0];
      dec.data8 = (fidx >= 4'h6);
      dec.stop2 = (fidx >= 4'h3 && fidx <= 4'h5) || (fidx >= 4'h9);
      dec.parity = spsd_parity_t'(2'(fidx % 4'h3));
    end else begin
      dec.rate_sel = RATE_STD;
      dec.data8 = 1'b0;
      dec.stop2 = 1'b1;
      dec.parity = SPSD_PAR_EVEN;
    end
    dec.delay_steps = dec.raw_mode ? 14'h0 : bcd4(r.delay_w);
    dec.node = dec.raw_mode ? 5'h00
             : 5'(r.station_w[7:4]) * 5'h0a + 5'(r.station_w[3:0]);
    dec.start_en = dec.raw_mode && scode == 4'h1;
    dec.start_code = dec.start_en ? r.delim_w[7:0] : 8'h00;
    dec.end_mode = dec.raw_mode ? spsd_end_t'(ecode[1:0]) : SPSD_END_COUNT;
    dec.end_code = r.delim_w[15:8];
    dec.rx_count = (r.delim_w[15:8] == 8'h00) ? 9'h100
                 : {1'b0, r.delim_w[15:8]};
    if (bad) begin
      dec = '0;
      dec.rate_sel = RATE_STD;
      dec.stop2 = 1'b1;
      dec.parity = SPSD_PAR_EVEN;
      dec.rx_count = 9'h100;
    end
    dlog.log_on = (r.log_w[3:0] <= 4'h1);
    dlog.keep_first = (r.log_w[3:0] == 4'h1);
    dlog.cyc_mon_on = (r.log_w[11:8] == 4'h0);
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic: register port, apply, interrupts, timer, log.
  always_comb begin
    logic [2:0] ev;
    next_r = r;
    next_r.go = 1'b0;
    next_r.log_wr = 1'b0;
    next_r.log_sh = 1'b0;
    ev = 3'h0;
    if (wr_i) begin
      case (addr_i)
        ADDR_MODE: next_r.mode_w = wdata_i;
        ADDR_RATE: next_r.rate_w = wdata_i;
        ADDR_DELAY: next_r.delay_w = wdata_i;
        ADDR_STATION: next_r.station_w = wdata_i;
        ADDR_DELIM: next_r.delim_w = wdata_i;
        ADDR_LOG: next_r.log_w = wdata_i;
        ADDR_IRQ_EN: next_r.irq_en = wdata_i[2:0];
        default: ;
      endcase
    end
    if (wr_i && addr_i == ADDR_APPLY) begin
      next_r.cfg = dec;
      next_r.logp = dlog;
      next_r.cfg_err = derr;
      next_r.log_cnt = 3'h0;
      ev[IRQ_CFG_ERR] = derr;
    end
    // long cycle reported only when monitoring.
    ev[IRQ_LONG_CYC] = long_cycle_i && r.logp.cyc_mon_on;
    if (error_event_i && r.logp.log_on) begin
      if (r.log_cnt < LOG_KEEP) begin
        next_r.log_wr = 1'b1;
        next_r.slot = r.log_cnt;
        next_r.log_cnt = r.log_cnt + 3'h1;
      end else if (!r.logp.keep_first) begin
        next_r.log_wr = 1'b1;
        next_r.log_sh = 1'b1;
        next_r.slot = 3'h6;
      end else begin
        ev[IRQ_LOG_FULL] = 1'b1;
      end
    end
    // Set wins over a clear in the same cycle.
    if (wr_i && addr_i == ADDR_IRQ_CLR) begin
      next_r.irq_stat = r.irq_stat & ~wdata_i[2:0];
    end
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_en);
    case (r.st)
      SPSD_ST_IDLE: begin
        if (reply_req_i) begin
          if (r.cfg.delay_steps == 14'h0) begin
            next_r.go = 1'b1;
          end else begin
            next_r.st = SPSD_ST_WAIT;
            next_r.steps = r.cfg.delay_steps;
            next_r.tick = 24'(DELAY_STEP_CYC - 1);
          end
        end
      end
      SPSD_ST_WAIT: begin
        if (r.tick != 24'h0) begin
          next_r.tick = r.tick - 24'h1;
        end else if (r.steps == 14'h1) begin
          next_r.st = SPSD_ST_GO;
        end else begin
          next_r.steps = r.steps - 14'h1;
          next_r.tick = 24'(DELAY_STEP_CYC - 1);
        end
      end
      SPSD_ST_GO: begin
        next_r.go = 1'b1;
        next_r.st = SPSD_ST_IDLE;
      end
      default: next_r.st = SPSD_ST_IDLE;
    endcase
    // Read data appears the cycle after the strobe; unmapped reads zero.
    next_r.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ADDR_MODE: next_r.rdata = r.mode_w;
        ADDR_RATE: next_r.rdata = r.rate_w;
        ADDR_DELAY: next_r.rdata = r.delay_w;
        ADDR_STATION: next_r.rdata = r.station_w;
        ADDR_DELIM: next_r.rdata = r.delim_w;
        ADDR_LOG: next_r.rdata = r.log_w;
        ADDR_IRQ_STAT: next_r.rdata = {13'h0, r.irq_stat};
        ADDR_IRQ_EN: next_r.rdata = {13'h0, r.irq_en};
        ADDR_STATUS: next_r.rdata = {12'h0, r.log_cnt, r.cfg_err};
        default: next_r.rdata = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; reset applies the standard host setup.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      r <= '0;
      r.cfg.rate_sel <= RATE_STD;
      r.cfg.stop2 <= 1'b1;
      r.cfg.rx_count <= 9'h100;
      r.logp.log_on <= 1'b1;
      r.logp.cyc_mon_on <= 1'b1;
      r.st <= SPSD_ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;
  assign cfg_o = r.cfg;
  assign log_o = r.logp;
  assign config_error_flag_o = r.cfg_err;
  assign reply_go_o = r.go;
  assign log_write_o = r.log_wr;
  assign log_slot_o = r.slot;
  assign log_shift_o = r.log_sh;
  assign irq_o = r.irq;

endmodule // spsd_top

// *** tb/spsd_asserts.sv ***
// Concurrent checks on the setup decoder's top-level ports.
// Assumes it is bound to spsd_top and shares its single clock.
`timescale 1ns/1ps
module spsd_asserts
  import spsd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic reply_req_i,
  input wire spsd_cfg_t cfg_o,
  input wire spsd_log_t log_o,
  input wire logic config_error_flag_o,
  input wire logic reply_go_o,
  input wire logic log_write_o,
  input wire logic [2:0] log_slot_o,
  input wire logic log_shift_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic ap;
  // Apply strobe; the decoded view may move one or two edges after it.
  assign ap = wr_i && (addr_i == ADDR_APPLY);
  AST_HOLD_UNTIL_APPLY: assert property (
    !$past(ap) && !$past(ap, 2) |->
      $stable({cfg_o, log_o, config_error_flag_o}))
    else $error("setup changed without apply");
  AST_FALLBACK_SAFE: assert property (
    config_error_flag_o |-> !cfg_o.raw_mode && cfg_o.rate_sel == RATE_STD
      && cfg_o.node == 5'h00 && cfg_o.delay_steps == 14'h0000
      && !cfg_o.data8 && cfg_o.stop2 && cfg_o.parity == SPSD_PAR_EVEN)
    else $error("fallback setup wrong");
  AST_COUNT_RANGE: assert property (
    cfg_o.rx_count != 9'h000 && cfg_o.rx_count <= 9'h100)
    else $error("receive count out of range");
  AST_FIELD_CODES: assert property (
    cfg_o.rate_sel <= 3'h4 && cfg_o.parity != 2'h3
      && cfg_o.end_mode != 2'h3)
    else $error("decoded code out of range");
  AST_NO_LOG_OFF: assert property (
    !log_o.log_on |-> !log_write_o && !log_shift_o)
    else $error("log written while disabled");
  AST_SHIFT_SLOT: assert property (
    log_shift_o |-> log_write_o && log_slot_o == 3'h6 && !log_o.keep_first)
    else $error("bad log shift");
  AST_PROMPT_REPLY: assert property (
    reply_req_i && cfg_o.delay_steps == 14'h0000 && !reply_go_o
      && $stable(cfg_o) |=> reply_go_o)
    else $error("zero delay reply late");
  AST_REPLY_CAUSE: assert property (
    $rose(reply_go_o) && cfg_o.delay_steps == 14'h0000 |->
      $past(reply_req_i))
    else $error("reply without request");
endmodule // spsd_asserts

// *** tb/spsd_host.sv ***
// Host-side model that asks the block for replies and times them.
// Assumes reply_go_i is a one-cycle pulse on the shared clock.
`timescale 1ns/1ps
module spsd_host (
  input wire logic clk_sys_i,
  input wire logic reply_go_i,
  output logic reply_req_o
);
  initial reply_req_o = 1'b0;
  // One request pulse, then count cycles until the reply may start.
  task automatic ask(input int limit, output int cyc);
    @(posedge clk_sys_i);
    reply_req_o <= 1'b1;
    @(posedge clk_sys_i);
    reply_req_o <= 1'b0;
    @(negedge clk_sys_i);
    cyc = 1;
    while (reply_go_i !== 1'b1 && cyc < limit) begin
      @(negedge clk_sys_i);
      cyc++;
    end
  endtask
endmodule // spsd_host

// *** tb/tb_serial_port_setup_decoder.sv ***
// Self-checking bench for the serial port setup decoder.
// Assumes spsd_top, the host model and the bound checker.
`timescale 1ns/1ps
module tb_serial_port_setup_decoder;
  import spsd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic long_cycle_i = 1'b0;
  logic error_event_i = 1'b0;
  logic reply_req_i, reply_go_o, config_error_flag_o, irq_o;
  logic log_write_o, log_shift_o;
  logic [2:0] log_slot_o;
  logic [15:0] rdata_o;
  spsd_cfg_t cfg_o;
  spsd_log_t log_o;
  int num_errors = 0;
  int compares = 0;
  int nw = 0;
  int ns = 0;
  int nsl = 0;
  int cyc;
  logic [63:0] bad [8] = '{64'h0002_0a02_0000_0000, 64'h2000_0a02_0000_0000,
    64'h0001_0005_0000_0000, 64'h0001_0c00_0000_0000,
    64'h0000_0a02_0000_0032, 64'h0000_0a02_00a0_0000,
    64'h1000_0a02_0000_0200, 64'h1000_0a02_0000_3000};
  always #4 clk_sys_i = ~clk_sys_i;
  spsd_top dut_u (.clk_sys_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .reply_req_i, .long_cycle_i, .error_event_i, .cfg_o, .log_o,
    .config_error_flag_o, .reply_go_o, .log_write_o, .log_slot_o,
    .log_shift_o, .irq_o);
  spsd_host host_u (.clk_sys_i, .reply_go_i(reply_go_o),
    .reply_req_o(reply_req_i));
  // Count log traffic at the falling edge, where the pulses have settled.
  always @(negedge clk_sys_i) begin
    if (log_write_o === 1'b1) begin
      nw++;
      nsl += int'(log_slot_o);
    end
    if (log_shift_o === 1'b1) ns++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] pk(input logic f, r, logic [2:0] rt,
    logic d8, s2, logic [1:0] p, logic [4:0] n);
    return {f, r, rt, d8, s2, p, 2'h0, n};
  endfunction
  function automatic logic [15:0] summ();
    return pk(config_error_flag_o, cfg_o.raw_mode, cfg_o.rate_sel,
      cfg_o.data8, cfg_o.stop2, cfg_o.parity, cfg_o.node);
  endfunction
  task automatic settle();
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [15:0] a, d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(rdata_o, exp);
  endtask
  task automatic put(input logic [15:0] m, r, d, s, c, l);
    wr(ADDR_MODE, m);
    wr(ADDR_RATE, r);
    wr(ADDR_DELAY, d);
    wr(ADDR_STATION, s);
    wr(ADDR_DELIM, c);
    wr(ADDR_LOG, l);
    wr(ADDR_APPLY, 16'h0001);
    settle();
  endtask
  task automatic pulse(input int n, input bit lc);
    nw = 0;
    ns = 0;
    nsl = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      if (lc) long_cycle_i <= 1'b1;
      else error_event_i <= 1'b1;
      @(posedge clk_sys_i);
      long_cycle_i <= 1'b0;
      error_event_i <= 1'b0;
    end
    settle();
  endtask
  // Defaults, unused bits, staging and mode select.
  task automatic t_basic();
    chk(summ(), pk(0, 0, 3, 0, 1, 0, 0));
    chk(16'(cfg_o.rx_count), 16'h0100);
    chk(16'(log_o), 16'h0005);
    rd(16'h0100, 16'h0000);
    put(16'h0ff0, 16'h0a02, 0, 0, 0, 0);
    chk(summ(), pk(0, 0, 3, 0, 1, 0, 0));
    wr(ADDR_MODE, 16'h1000);
    settle();
    chk(summ(), pk(0, 0, 3, 0, 1, 0, 0));
    rd(ADDR_MODE, 16'h1000);
    wr(ADDR_APPLY, 16'h0001);
    settle();
    chk(summ(), pk(0, 1, 3, 0, 1, 0, 0));
    put(0, 0, 0, 16'h0031, 0, 0);
    chk(summ(), pk(0, 0, 3, 0, 1, 0, 31));
  endtask
  // Every frame format code with a spread of rate codes.
  task automatic t_formats();
    for (int f = 0; f < 12; f++) begin
      put(16'h0001, 16'((f << 8) + f % 5), 0, 0, 0, 0);
      chk(summ(), pk(0, 0, 3'(f % 5), f >= 6, f % 6 >= 3, 2'(f % 3), 0));
    end
  endtask
  // Bad codes fall back and raise the flag and its interrupt.
  task automatic t_invalid();
    foreach (bad[i]) begin
      put(bad[i][63:48], bad[i][47:32], bad[i][31:16], bad[i][15:0], 0, 0);
      chk(summ(), pk(1, 0, 3, 0, 1, 0, 0));
    end
    wr(ADDR_IRQ_EN, 16'h0001);
    settle();
    chk(16'(irq_o), 16'h0001);
    rd(ADDR_IRQ_STAT, 16'h0001);
    wr(ADDR_IRQ_CLR, 16'h0007);
    settle();
    chk(16'(irq_o), 16'h0000);
    put(0, 0, 0, 0, 0, 0);
    chk(summ(), pk(0, 0, 3, 0, 1, 0, 0));
  endtask
  // Raw mode delimiters and receive count.
  task automatic t_raw();
    put(16'h1000, 0, 0, 16'h2100, 16'h0041, 0);
    chk(16'({cfg_o.start_en, cfg_o.end_mode, cfg_o.start_code}),
      {5'h00, 1'b1, SPSD_END_CRLF, 8'h41});
    put(16'h1000, 0, 0, 16'h0000, 16'h0541, 0);
    chk(16'({cfg_o.start_en, cfg_o.end_mode}), 16'h0000);
    chk(16'(cfg_o.rx_count), 16'h0005);
    put(16'h1000, 0, 0, 16'h1000, 16'ha500, 0);
    chk(16'({cfg_o.end_mode, cfg_o.end_code}),
      {6'h00, SPSD_END_CODE, 8'ha5});
    put(16'h1000, 0, 0, 16'h0100, 16'h0000, 0);
    chk(16'(cfg_o.rx_count), 16'h0100);
    chk(16'(cfg_o.start_en), 16'h0001);
  endtask
  // Reply delay; a pending long wait is cut short by a reset.
  task automatic t_delay();
    put(0, 0, 16'h9999, 0, 0, 0);
    chk(16'(cfg_o.delay_steps), 16'h270f);
    put(0, 0, 0, 0, 0, 0);
    host_u.ask(10, cyc);
    chk(16'(cyc), 16'h0001);
    put(0, 0, 16'h0001, 0, 0, 0);
    host_u.ask(200, cyc);
    chk(16'(cyc), 16'h00c8);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    settle();
  endtask
  // Log styles and the cycle time monitor.
  task automatic t_log();
    put(0, 0, 0, 0, 0, 0);
    pulse(8, 0);
    chk(16'(nw * 16 + ns), 16'h0081);
    chk(16'(nsl), 16'h001b);
    rd(ADDR_STATUS, 16'h000e);
    put(0, 0, 0, 0, 0, 16'h0001);
    wr(ADDR_IRQ_EN, 16'h0006);
    rd(ADDR_IRQ_EN, 16'h0006);
    pulse(8, 0);
    chk(16'(nw * 16 + ns + irq_o), 16'h0071);
    chk(16'(nsl), 16'h0015);
    put(0, 0, 0, 0, 0, 16'h0002);
    pulse(3, 0);
    chk(16'(nw), 16'h0000);
    wr(ADDR_IRQ_CLR, 16'h0007);
    put(0, 0, 0, 0, 0, 16'h0100);
    chk(16'(log_o), 16'h0004);
    pulse(1, 1);
    rd(ADDR_IRQ_STAT, 16'h0000);
    put(0, 0, 0, 0, 0, 0);
    pulse(1, 1);
    rd(ADDR_IRQ_STAT, 16'h0002);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence after three reset cycles.
  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    settle();
    t_basic();
    t_formats();
    t_invalid();
    t_raw();
    t_delay();
    t_log();
    tally_and_finish();
  end
  // Watchdog well beyond the roughly 7 us the tests need.
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end
endmodule // tb_serial_port_setup_decoder
bind spsd_top spsd_asserts chk_u (.clk_sys_i, .sys_rst_i, .addr_i, .wr_i,
  .reply_req_i, .cfg_o, .log_o, .config_error_flag_o, .reply_go_o,
  .log_write_o, .log_slot_o, .log_shift_o);
